// [rtl/osd_debouncer.sv]
// Purpose: Octal switch debouncer with bus read port and change flag.
// Assumes: Reset stands for the undervoltage lockout; inputs synchronous to clk.
// Notes:   Data output is registered, so it follows the debounced state one cycle late.
`default_nettype none
module osd_debouncer #(
   parameter int DebounceCount = osd_pkg::DebounceCyc
) (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic [osd_pkg::NumChan-1:0]   switchIn,
   input  wire logic                          readEn_n,
   output var  logic [osd_pkg::NumChan-1:0]   dataOut,
   output var  logic [osd_pkg::NumChan-1:0]   dataOe,
   output var  logic                          change_flag_n
);
   import osd_pkg::*;

   // The count is cut to the counter width on purpose; the real delay fits in 20 bits.
   localparam logic [19:0] CountCyc = 20'(DebounceCount);

   logic [NumChan-1:0] stateW;
   logic [NumChan-1:0] prev_reg;
   logic [NumChan-1:0] data_reg;
   logic [NumChan-1:0] oe_reg;
   logic               flag_reg;
   logic               flag_next;

   genvar g;
   generate
      for (g = 0; g < NumChan; g++) begin : gChan
         osd_channel #(.Count(CountCyc)) uChan (
            .clk       (clk),
            .reset     (reset),
            .rawIn     (switchIn[g]),
            .stableOut (stateW[g])
         );
      end
   endgenerate

   wire anyChange = stateW != prev_reg;
   wire readNow   = !readEn_n;

   // A change in the read cycle wins, so the event is never lost.
   assign flag_next = anyChange ? 1'b0 : (readNow ? 1'b1 : flag_reg);

   always_ff @(posedge clk) begin
      if (reset) begin
         prev_reg <= DataReset;
         data_reg <= DataReset;
         oe_reg   <= '0;
         flag_reg <= 1'b1;
      end else begin
         prev_reg <= stateW;
         data_reg <= stateW;
         oe_reg   <= {NumChan{readNow}};
         flag_reg <= flag_next;
      end
   end

   assign dataOut       = data_reg;
   assign dataOe        = oe_reg;
   assign change_flag_n = flag_reg;

   chk_oe_follows_en: assert property (@(posedge clk) disable iff (reset)
      ##1 dataOe == {NumChan{!$past(readEn_n)}})
      else $error("Data enable does not follow read enable.");

   chk_flag_set_on_change: assert property (@(posedge clk) disable iff (reset)
      anyChange |=> !change_flag_n)
      else $error("Change flag not asserted after state change.");

   chk_flag_clear_on_read: assert property (@(posedge clk) disable iff (reset)
      (!readEn_n && !anyChange) |=> change_flag_n)
      else $error("Change flag not cleared by read.");

   chk_flag_holds_low: assert property (@(posedge clk) disable iff (reset)
      (!change_flag_n && readEn_n) |=> !change_flag_n)
      else $error("Change flag released without a read.");

   chk_data_matches: assert property (@(posedge clk) disable iff (reset)
      dataOut == prev_reg)
      else $error("Data word does not match debounced state.");

   chk_reset_state: assert property (@(posedge clk)
      reset |=> (change_flag_n && dataOe == '0 && dataOut == DataReset))
      else $error("Outputs not in defined state during lockout.");

   chk_state_stable: assert property (@(posedge clk) disable iff (reset)
      (stateW[0] != $past(stateW[0])) |-> ($past(switchIn[0]) == stateW[0]))
      else $error("Channel changed without stable input.");

   chk_no_bounce_update: assert property (@(posedge clk) disable iff (reset)
      (switchIn[0] != $past(switchIn[0])) |=> $stable(stateW[0]))
      else $error("Channel updated right after input moved.");

   chk_oe_idle_low: assert property (@(posedge clk) disable iff (reset)
      readEn_n |=> (dataOe == '0))
      else $error("Data pins driven without a read.");

   chk_oe_read_high: assert property (@(posedge clk) disable iff (reset)
      !readEn_n |=> (dataOe == '1))
      else $error("Data pins not driven during a read.");

   chk_flag_fall_cause: assert property (@(posedge clk) disable iff (reset)
      $fell(change_flag_n) |-> $past(anyChange))
      else $error("Change flag fell with no state change.");

   chk_flag_rise_cause: assert property (@(posedge clk) disable iff (reset)
      $rose(change_flag_n) |-> !$past(readEn_n))
      else $error("Change flag rose with no read.");

   chk_data_held: assert property (@(posedge clk) disable iff (reset)
      (stateW == prev_reg) |=> $stable(dataOut))
      else $error("Data word moved with no state change.");

   // Each channel is checked on its own, since one stuck filter would not show on channel 0.
   // The run counters below are checking aids only; no output depends on them.
   for (g = 0; g < NumChan; g++) begin : gChk
      logic [19:0] runCnt_reg;
      logic        lastIn_reg;
      wire         runSame = switchIn[g] == lastIn_reg;
      wire         runMax  = runCnt_reg == RunSat;
      wire  [19:0] runNext = runMax ? runCnt_reg : runCnt_reg + 20'h00001;

      always_ff @(posedge clk) begin
         if (reset) begin
            runCnt_reg <= 20'h00000;
            lastIn_reg <= 1'b1;
         end else begin
            lastIn_reg <= switchIn[g];
            runCnt_reg <= runSame ? runNext : 20'h00000;
         end
      end

      chk_chan_delay: assert property (@(posedge clk) disable iff (reset)
         (stateW[g] != $past(stateW[g])) |-> (runCnt_reg >= CountCyc - 20'h00001))
         else $error("Channel changed before its input was stable long enough.");

      chk_chan_settle: assert property (@(posedge clk) disable iff (reset)
         (stateW[g] != $past(stateW[g])) |-> ($past(switchIn[g]) == stateW[g]))
         else $error("Channel settled to a level its input did not hold.");

      chk_chan_bounce: assert property (@(posedge clk) disable iff (reset)
         (switchIn[g] != $past(switchIn[g])) |=> $stable(stateW[g]))
         else $error("Channel updated right after its input moved.");

      chk_chan_word: assert property (@(posedge clk) disable iff (reset)
         (dataOut[g] != $past(dataOut[g])) |-> (dataOut[g] == $past(stateW[g])))
         else $error("Data bit does not follow its channel.");

      chk_chan_oe_same: assert property (@(posedge clk) disable iff (reset)
         dataOe[g] == dataOe[0])
         else $error("Data enables differ between bits.");
   end
endmodule
`default_nettype wire

// [include/osd_pkg.sv]
// Purpose: Shared constants for the octal switch debouncer.
// Assumes: 10 MHz system clock.
// Notes:   Debounce time is held in microseconds and converted to cycles.
`default_nettype none
package osd_pkg;
   localparam int          NumChan     = 8;
   localparam int          ClockHz     = 10_000_000;
   localparam int          DebounceUs  = 40_000;
   localparam int          DebounceCyc = (DebounceUs / 1_000) * (ClockHz / 1_000);
   // Longest run that a stability counter tracks before it saturates.
   localparam logic [19:0] RunSat      = 20'hfffff;
   localparam int          CntWidth    = 20;
   localparam logic [7:0]  DataReset   = 8'hff;
endpackage
`default_nettype wire

// [rtl/osd_channel.sv]
// Purpose: One debounce filter for a single switch input.
// Assumes: Raw input synchronous to clk.
// Notes:   Output changes only after the input holds a new level for the full count.
`default_nettype none
module osd_channel #(
   parameter logic [19:0] Count = 20'(osd_pkg::DebounceCyc)
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic rawIn,
   output var  logic stableOut
);
   logic [19:0] cnt_reg;
   logic [19:0] cnt_next;
   logic        stable_reg;
   logic        stable_next;
   wire         differs = rawIn != stable_reg;
   wire         done    = cnt_reg == Count - 20'h00001;

   // Any return to the stable level restarts the timer, so bouncing never updates.
   assign cnt_next    = (!differs || done) ? 20'h00000 : cnt_reg + 20'h00001;
   assign stable_next = (differs && done) ? rawIn : stable_reg;
   assign stableOut   = stable_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg    <= 20'h00000;
         stable_reg <= 1'b1;
      end else begin
         cnt_reg    <= cnt_next;
         stable_reg <= stable_next;
      end
   end

   // The counter wraps back to zero on the last count, so it can never pass the limit.
   chk_count_bound: assert property (@(posedge clk) disable iff (reset)
      cnt_reg < Count)
      else $error("Debounce counter ran past its limit.");
endmodule
`default_nettype wire

// [tb/osd_host.sv]
// Purpose: Host model that reads the data word on request or on the change flag.
// Assumes: Design drives dataOe for all bits together.
// Notes:   A flag that stays low keeps the enable low, so reads may come back to back.
`default_nettype none
module osd_host (
   input  wire logic       clk,
   input  wire logic       req,
   input  wire logic       change_flag_n,
   input  wire logic [7:0] dataOut,
   input  wire logic [7:0] dataOe,
   output var  logic       readEn_n,
   output var  logic [7:0] got
);
   initial readEn_n = 1'b1;
   always @(posedge clk) begin
      readEn_n <= ~(req | ~change_flag_n);
      if (dataOe == 8'hff) got <= dataOut;
   end
endmodule
`default_nettype wire

// [tb/octal_switch_debouncer_test.sv]
// Purpose: Self-checking bench for the octal switch debouncer.
// Assumes: A short debounce count, so one settle takes about 16 cycles.
// Notes:   Random bounce comes from an LFSR seeded with 32'hba15.
`default_nettype none
module octal_switch_debouncer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import osd_pkg::*;
   // The filter works the same at any count; the full one would take far too long.
   localparam int TbDebounce = 16;
   logic        clk = 0, reset = 1, req = 0, rdN, flagN, mValid = 0, mFlag = 1;
   logic [7:0]  sw = 8'hff, dOut, dOe, got, expd = 8'hff, mSt = 8'hff, mOut = 8'hff, mOe = 0;
   logic [31:0] lfsr = 32'hba15;
   int          n_mismatch = 0, num_checks = 0, cyc = 0;
   int          mCnt [8];
   osd_debouncer #(.DebounceCount(TbDebounce)) i_osd_debouncer (.clk(clk), .reset(reset),
      .switchIn(sw), .readEn_n(rdN), .dataOut(dOut), .dataOe(dOe), .change_flag_n(flagN));
   osd_host i_osd_host (.clk(clk), .req(req), .change_flag_n(flagN), .dataOut(dOut),
      .dataOe(dOe), .readEn_n(rdN), .got(got));
   initial forever #50 clk = ~clk;
   function automatic logic [31:0] lfsrNext(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Reference model, stepped on the same edges as the design and checked half a cycle later.
   always @(posedge clk) begin
      if (reset) begin
         mValid = 1'b1;
         mSt    = 8'hff;
         mOut   = 8'hff;
         mOe    = 8'h00;
         mFlag  = 1'b1;
         foreach (mCnt[i]) mCnt[i] = 0;
      end else begin
         mFlag = (mSt != mOut) ? 1'b0 : (!rdN ? 1'b1 : mFlag);
         mOut  = mSt;
         mOe   = {8{!rdN}};
         for (int i = 0; i < 8; i++) begin
            if (sw[i] == mSt[i]) mCnt[i] = 0;
            else if (mCnt[i] == TbDebounce - 1) begin
               mSt[i]  = sw[i];
               mCnt[i] = 0;
            end else mCnt[i] = mCnt[i] + 1;
         end
      end
   end
   always @(negedge clk) begin
      if (mValid) begin
         chk(dOut, mOut, "model data");
         chk(dOe, mOe, "model oe");
         chk({7'h0, flagN}, {7'h0, mFlag}, "model flag");
      end
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // The scenarios need about 3100 cycles; the ceiling leaves some margin.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 4000) begin
         n_mismatch++;
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      reset <= 0;
      @(negedge clk) chk(dOe, 8'h00, "oe");
      chk({7'h0, flagN}, 8'h01, "flag");
      @(posedge clk) req <= 1;
      @(posedge clk) req <= 0;
      @(posedge clk);
      @(negedge clk) chk(dOe, 8'hff, "oe");
      chk(dOut, expd, "data");
      @(negedge clk) chk(dOe, 8'h00, "oe");
      // Changes come in bursts with quiet gaps, so some channels settle and some bounce.
      repeat (3000) @(posedge clk) begin
         lfsr = lfsrNext(lfsr);
         if (lfsr[12:10] == 3'h0) sw <= lfsr[7:0];
      end
      // Park at the old level long enough that every channel settles and the flag is read.
      @(posedge clk) sw <= 8'hff;
      repeat (TbDebounce + 8) @(posedge clk);
      @(negedge clk) chk({7'h0, flagN}, 8'h01, "flag");
      @(posedge clk) sw <= 8'ha5;
      expd = 8'ha5;
      repeat (TbDebounce) @(posedge clk);
      @(negedge clk) chk({7'h0, flagN}, 8'h01, "flag");
      @(negedge clk) chk({7'h0, flagN}, 8'h00, "flag");
      repeat (5) @(posedge clk);
      @(negedge clk) chk(got, expd, "read");
      chk({7'h0, flagN}, 8'h01, "flag");
      test_done;
   end
endmodule
`default_nettype wire
